// [tb/acwake_host_model.sv]
// Purpose: Host software model issuing APB byte register transfers
// Assumes: Zero or more wait states, pready sampled at rising edge
// Notes:   Released address and data are inverted, not left at last value
`timescale 1ns/1ps
`default_nettype none
module acwake_host_model (
	input  wire logic                          pclk,
	output var  logic                          psel,
	output var  logic                          penable,
	output var  logic                          pwrite,
	output var  logic [acwake_pkg::ADDR_W-1:0] paddr,
	output var  logic [31:0]                   pwdata,
	output var  logic [3:0]                    pstrb,
	input  wire logic [31:0]                   prdata,
	input  wire logic                          pready
);
	import acwake_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
	end
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
			output logic [7:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~{idx, 2'b00};
		pwdata <= ~{24'h0, wd};
	endtask
endmodule
`default_nettype wire

// [tb/tb_acpi_child_wake_event_regs.sv]
// Purpose: Self-checking bench for the child wake-event register block
// Assumes: Zero-wait APB slave, three-cycle event capture latency
// Notes:   All-word reset reads first, then register rows, event, global flag and reset cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_acpi_child_wake_event_regs;
	import acwake_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, sci_out;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        pslverr;
	logic [7:0]  p0 = '0;
	logic [3:0]  p1 = '0;
	logic [1:0]  mode = KMODE_SEQ;
	logic k3 = 0, k2 = 0, k1 = 0, ptr = 0, anyk = 0, phone = 1;
	logic lirq = 0, len = 0, lact = 0, pirq = 0, pen = 0, kirq = 0, ken = 0, kact = 0;
	int num_errors = 0, checked = 0;
	logic [3:0] ridx [6] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h4, 4'h1};
	logic [7:0] rexp [6] = '{8'hFF, 8'h0F, 8'hFC, 8'h1C, 8'h01, 8'h00};
	always #4 pclk = ~pclk;
	acwake_host_model acwake_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready));
	acwake_regs acwake_regs_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin_event(p0),
		.port1_pin_event(p1), .key_detector_mode(mode), .pm_key3_hit(k3), .pm_key2_hit(k2),
		.key_event_hit(k1), .pointer_event_hit(ptr), .any_key_hit(anyk),
		.phone_call_indicator_input(phone), .legacy_unit_irq(lirq),
		.legacy_unit_wake_en(len), .legacy_unit_active(lact), .pointer_irq(pirq),
		.pointer_irq_wake_en(pen), .keypad_irq(kirq), .keypad_irq_wake_en(ken),
		.keypad_controller_unit_active(kact), .sci_out(sci_out));
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		logic [7:0] q;
		acwake_host_model_i.xfer(1'b1, i, d, q);
	endtask
	task automatic rc(input logic [3:0] i, input logic [7:0] e);
		logic [7:0] q;
		acwake_host_model_i.xfer(1'b0, i, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic hold();
		repeat (6) @(posedge pclk);
	endtask
	task automatic stop_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) rc(i[3:0], 8'h00);
		`CHK(pslverr, 1'b0)
		for (int r = 0; r < 6; r++) begin
			wr(ridx[r], 8'hFF);
			rc(ridx[r], rexp[r]);
			wr(ridx[r], 8'h00);
		end
		p1 <= 4'hF;
		p0 <= 8'hA5;
		hold();
		p1 <= 4'h0;
		p0 <= 8'h00;
		hold();
		rc(4'h9, 8'h0F);
		rc(4'h8, 8'hA5);
		wr(4'h9, 8'h01);
		rc(4'h9, 8'h0E);
		{k3, k2, k1, anyk} <= 4'hF;
		hold();
		{k3, k2, k1, anyk} <= 4'h0;
		hold();
		rc(4'hA, 8'h20);
		wr(4'hA, 8'hFC);
		mode <= KMODE_PMKEYS;
		hold();
		{k3, k2, ptr, anyk} <= 4'hF;
		hold();
		{k3, k2, ptr, anyk} <= 4'h0;
		hold();
		rc(4'hA, 8'hD0);
		wr(4'hA, 8'hFC);
		mode <= KMODE_ANYKEY;
		hold();
		{anyk, phone} <= 2'b10;
		hold();
		{anyk, phone} <= 2'b01;
		hold();
		rc(4'hA, 8'h0C);
		{lirq, len, lact, pirq, kirq, ken, kact} <= 7'h7F;
		hold();
		{lirq, pirq, kirq} <= 3'h0;
		hold();
		rc(4'hB, 8'h14);
		wr(4'hB, 8'hFF);
		{lact, pen, ken} <= 3'b010;
		hold();
		{lirq, pirq, kirq} <= 3'h7;
		hold();
		{lirq, pirq, kirq} <= 3'h0;
		hold();
		rc(4'hB, 8'h08);
		wr(4'hE, 8'h04);
		wr(4'h4, 8'h01);
		hold();
		rc(4'h0, 8'h01);
		`CHK(sci_out, 1'b1)
		wr(4'h0, 8'h01);
		rc(4'h0, 8'h01);
		wr(4'hA, 8'h04);
		wr(4'h0, 8'h01);
		rc(4'h0, 8'h00);
		`CHK(sci_out, 1'b0)
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rc(4'hE, 8'h00);
		rc(4'hA, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire

// [verilog/acwake_pkg.sv]
// Purpose: Shared constants for the child wake-event register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Printed offsets are register indices; byte address is four times the index
package acwake_pkg;
	localparam logic [3:0] IDX_GLB_STS  = 4'h0;
	localparam logic [3:0] IDX_GLB_EN   = 4'h4;
	localparam logic [3:0] IDX_STS_P0   = 4'h8;
	localparam logic [3:0] IDX_STS_P1   = 4'h9;
	localparam logic [3:0] IDX_STS_DEV  = 4'hA;
	localparam logic [3:0] IDX_STS_IRQ  = 4'hB;
	localparam logic [3:0] IDX_EN_P0    = 4'hC;
	localparam logic [3:0] IDX_EN_P1    = 4'hD;
	localparam logic [3:0] IDX_EN_DEV   = 4'hE;
	localparam logic [3:0] IDX_EN_IRQ   = 4'hF;
	localparam int         ADDR_W       = 6;
	// Implemented bits per register
	localparam logic [7:0] MASK_P0      = 8'hFF;
	localparam logic [7:0] MASK_P1      = 8'h0F;
	localparam logic [7:0] MASK_DEV     = 8'hFC;
	localparam logic [7:0] MASK_IRQ     = 8'h1C;
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	// Synchroniser reset: phone indicator idles high, all others low
	localparam logic [20:0] SYNC_RESET  = 21'h100000;
	// Field positions in the input-device register
	localparam int         BIT_KEY3     = 7;
	localparam int         BIT_KEY2     = 6;
	localparam int         BIT_KEY1     = 5;
	localparam int         BIT_POINTER  = 4;
	localparam int         BIT_ANYKEY   = 3;
	localparam int         BIT_PHONE    = 2;
	// Field positions in the module IRQ register
	localparam int         BIT_UNIT_IRQ = 4;
	localparam int         BIT_PTR_IRQ  = 3;
	localparam int         BIT_KEY_IRQ  = 2;
	// Wake detector modes
	typedef enum logic [3:0] {
		ACWAKE_MODE_SEQ    = 4'h1,
		ACWAKE_MODE_PMKEYS = 4'h2,
		ACWAKE_MODE_ANYKEY = 4'h4,
		ACWAKE_MODE_PASSWD = 4'h8
	} acwake_mode_e;
	localparam logic [1:0] KMODE_SEQ    = 2'h0;
	localparam logic [1:0] KMODE_ANYKEY = 2'h1;
	localparam logic [1:0] KMODE_PMKEYS = 2'h2;
	localparam logic [1:0] KMODE_PASSWD = 2'h3;
endpackage

// [verilog/acwake_regs.sv]
// Purpose: Sticky child wake-event status, enables and global wake flag
// Assumes: Event sources are asynchronous and pass a two-stage synchroniser
// Notes:   Zero-wait APB slave; unmapped words read zero and take no effect
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module acwake_regs (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       clk_en,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [acwake_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [7:0]                 port0_pin_event,
	input  wire logic [3:0]                 port1_pin_event,
	input  wire logic [1:0]                 key_detector_mode,
	input  wire logic                       pm_key3_hit,
	input  wire logic                       pm_key2_hit,
	input  wire logic                       key_event_hit,
	input  wire logic                       pointer_event_hit,
	input  wire logic                       any_key_hit,
	input  wire logic                       phone_call_indicator_input,
	input  wire logic                       legacy_unit_irq,
	input  wire logic                       legacy_unit_wake_en,
	input  wire logic                       legacy_unit_active,
	input  wire logic                       pointer_irq,
	input  wire logic                       pointer_irq_wake_en,
	input  wire logic                       keypad_irq,
	input  wire logic                       keypad_irq_wake_en,
	input  wire logic                       keypad_controller_unit_active,
	output logic                            sci_out
);
	import acwake_pkg::*;

	localparam int NSRC = 21;

	// Raw asynchronous sources, two flops each before use
	logic [NSRC-1:0] src_raw;
	logic [NSRC-1:0] sync_q1;
	logic [NSRC-1:0] sync_q2;
	logic            phone_prev;

	logic [7:0] sts_p0;
	logic [7:0] sts_p1;
	logic [7:0] sts_dev;
	logic [7:0] sts_irq;
	logic [7:0] en_p0;
	logic [7:0] en_p1;
	logic [7:0] en_dev;
	logic [7:0] en_irq;
	logic       global_wake_flag;
	logic       global_wake_gate;

	logic [7:0] set_p0;
	logic [7:0] set_p1;
	logic [7:0] set_dev;
	logic [7:0] set_irq;
	logic       wr_acc;
	logic [3:0] widx;
	logic [7:0] wbyte;
	logic       any_enabled;
	logic [1:0] kmode_q;

	function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] set,
		input logic hit, input logic [7:0] wb, input logic [7:0] msk);
		logic [7:0] clr;
		clr = hit ? (wb & msk) : 8'h00;
		w1c_next = ((cur & ~clr) | set) & msk;
	endfunction

	assign src_raw = {phone_call_indicator_input, keypad_irq, pointer_irq, legacy_unit_irq,
		any_key_hit, pointer_event_hit, key_event_hit, pm_key2_hit, pm_key3_hit,
		port1_pin_event, port0_pin_event};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q1 <= SYNC_RESET;
			sync_q2 <= SYNC_RESET;
		end else if (clk_en) begin
			sync_q1 <= src_raw;
			sync_q2 <= sync_q1;
		end
	end

	// Mode select is a config level, also synchronised
	logic [1:0] kmode_q1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kmode_q1 <= KMODE_SEQ;
			kmode_q  <= KMODE_SEQ;
		end else if (clk_en) begin
			kmode_q1 <= key_detector_mode;
			kmode_q  <= kmode_q1;
		end
	end

	// Idle high so release of reset is no falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phone_prev <= 1'b1;
		end else if (clk_en) begin
			phone_prev <= sync_q2[20];
		end
	end

	logic         wake_ok_unit;
	logic         wake_ok_ptr;
	logic         wake_ok_key;
	acwake_mode_e mode_oh;

	always_comb begin
		case (kmode_q)
			KMODE_SEQ:    mode_oh = ACWAKE_MODE_SEQ;
			KMODE_ANYKEY: mode_oh = ACWAKE_MODE_ANYKEY;
			KMODE_PMKEYS: mode_oh = ACWAKE_MODE_PMKEYS;
			KMODE_PASSWD: mode_oh = ACWAKE_MODE_PASSWD;
			default:      mode_oh = ACWAKE_MODE_SEQ;
		endcase
	end

	// Wake enables and activity are config levels from the same well
	assign wake_ok_unit = legacy_unit_wake_en && legacy_unit_active;
	assign wake_ok_ptr  = pointer_irq_wake_en && keypad_controller_unit_active;
	assign wake_ok_key  = keypad_irq_wake_en && keypad_controller_unit_active;

	always_comb begin
		set_p0  = sync_q2[7:0];
		set_p1  = {4'h0, sync_q2[11:8]};
		set_dev = 8'h00;
		set_dev[BIT_KEY3]    = sync_q2[12] && (mode_oh == ACWAKE_MODE_PMKEYS);
		set_dev[BIT_KEY2]    = sync_q2[13] && (mode_oh == ACWAKE_MODE_PMKEYS);
		set_dev[BIT_KEY1]    = sync_q2[14] && (mode_oh != ACWAKE_MODE_ANYKEY);
		set_dev[BIT_POINTER] = sync_q2[15];
		set_dev[BIT_ANYKEY]  = sync_q2[16] && (mode_oh == ACWAKE_MODE_ANYKEY);
		set_dev[BIT_PHONE]   = phone_prev && !sync_q2[20];
		set_irq = 8'h00;
		set_irq[BIT_UNIT_IRQ] = sync_q2[17] && wake_ok_unit;
		set_irq[BIT_PTR_IRQ]  = sync_q2[18] && wake_ok_ptr;
		set_irq[BIT_KEY_IRQ]  = sync_q2[19] && wake_ok_key;
	end

	// Write takes effect in the access cycle; low byte lane only
	assign wr_acc = psel && penable && pwrite && pstrb[0] && (paddr[1:0] == 2'b00);
	assign widx   = paddr[5:2];
	assign wbyte  = pwdata[7:0];

	// Set wins over a simultaneous clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_p0  <= RESET_BYTE;
			sts_p1  <= RESET_BYTE;
			sts_dev <= RESET_BYTE;
			sts_irq <= RESET_BYTE;
		end else if (clk_en) begin
			sts_p0  <= w1c_next(sts_p0, set_p0, wr_acc && widx == IDX_STS_P0, wbyte, MASK_P0);
			sts_p1  <= w1c_next(sts_p1, set_p1, wr_acc && widx == IDX_STS_P1, wbyte, MASK_P1);
			sts_dev <= w1c_next(sts_dev, set_dev, wr_acc && widx == IDX_STS_DEV, wbyte, MASK_DEV);
			sts_irq <= w1c_next(sts_irq, set_irq, wr_acc && widx == IDX_STS_IRQ, wbyte, MASK_IRQ);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_p0  <= RESET_BYTE;
			en_p1  <= RESET_BYTE;
			en_dev <= RESET_BYTE;
			en_irq <= RESET_BYTE;
			global_wake_gate <= 1'b0;
		end else if (clk_en && wr_acc) begin
			if (widx == IDX_EN_P0)  en_p0  <= wbyte & MASK_P0;
			if (widx == IDX_EN_P1)  en_p1  <= wbyte & MASK_P1;
			if (widx == IDX_EN_DEV) en_dev <= wbyte & MASK_DEV;
			if (widx == IDX_EN_IRQ) en_irq <= wbyte & MASK_IRQ;
			if (widx == IDX_GLB_EN) global_wake_gate <= wbyte[0];
		end
	end

	assign any_enabled = |{sts_p0 & en_p0, sts_p1 & en_p1, sts_dev & en_dev, sts_irq & en_irq};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_wake_flag <= 1'b0;
		end else if (clk_en) begin
			if (any_enabled) begin
				global_wake_flag <= 1'b1;
			end else if (wr_acc && widx == IDX_GLB_STS && wbyte[0]) begin
				global_wake_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sci_out <= 1'b0;
		end else if (clk_en) begin
			sci_out <= global_wake_flag && global_wake_gate;
		end
	end

	// Read data registered in the setup cycle
	logic [7:0] rbyte;
	always_comb begin
		case (paddr[5:2])
			IDX_GLB_STS: rbyte = {7'h00, global_wake_flag};
			IDX_GLB_EN:  rbyte = {7'h00, global_wake_gate};
			IDX_STS_P0:  rbyte = sts_p0;
			IDX_STS_P1:  rbyte = sts_p1;
			IDX_STS_DEV: rbyte = sts_dev;
			IDX_STS_IRQ: rbyte = sts_irq;
			IDX_EN_P0:   rbyte = en_p0;
			IDX_EN_P1:   rbyte = en_p1;
			IDX_EN_DEV:  rbyte = en_dev;
			IDX_EN_IRQ:  rbyte = en_irq;
			default:     rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (clk_en && psel && !penable) begin
			prdata <= (paddr[1:0] == 2'b00) ? {24'h000000, rbyte} : 32'h00000000;
		end
	end

	assign pready  = clk_en;
	assign pslverr = 1'b0;

	sts_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sts_dev[BIT_POINTER] && !(wr_acc && widx == IDX_STS_DEV && wbyte[BIT_POINTER])
		|=> sts_dev[BIT_POINTER])
		else $error("pointer flag dropped without clear");
	clr_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_acc && widx == IDX_STS_P0 && wbyte[0] && !set_p0[0] |=> !sts_p0[0])
		else $error("port0 flag not cleared by one");
	pin_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_p1[3] |=> sts_p1[3])
		else $error("port1 pin3 event not recorded");
	pmkey_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && $rose(sts_dev[BIT_KEY3]) |-> $past(mode_oh) == ACWAKE_MODE_PMKEYS)
		else $error("pm key flag outside pm-keys mode");
	anykey_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_dev[BIT_ANYKEY]) |-> $past(mode_oh) == ACWAKE_MODE_ANYKEY)
		else $error("any-key flag outside any-key mode");
	phone_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && phone_prev && !sync_q2[20] |=> sts_dev[BIT_PHONE])
		else $error("phone falling edge missed");
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_irq[BIT_PTR_IRQ]) |-> $past(wake_ok_ptr))
		else $error("pointer irq flag without wake enable");
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(sts_p1[7:4] == 4'h0) && (sts_dev[1:0] == 2'b00) && (en_irq[7:5] == 3'h0))
		else $error("reserved bit set");
	glb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		any_enabled && clk_en |=> global_wake_flag)
		else $error("global flag not set by enabled child");
	sci_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && global_wake_flag && global_wake_gate |=> sci_out)
		else $error("interrupt not driven");

	ptr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_dev[BIT_POINTER] |=> sts_dev[BIT_POINTER])
		else $error("pointer event not recorded");

	key1_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sync_q2[14] && (mode_oh != ACWAKE_MODE_ANYKEY) |=> sts_dev[BIT_KEY1])
		else $error("key event not recorded");

	key1_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_dev[BIT_KEY1]) |-> $past(mode_oh) != ACWAKE_MODE_ANYKEY)
		else $error("key event flag in any-key mode");

	key3_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sync_q2[12] && (mode_oh == ACWAKE_MODE_PMKEYS) |=> sts_dev[BIT_KEY3])
		else $error("pm key 3 not recorded");

	key2_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_dev[BIT_KEY2]) |-> $past(mode_oh) == ACWAKE_MODE_PMKEYS)
		else $error("pm key 2 flag outside pm-keys mode");

	unit_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_irq[BIT_UNIT_IRQ]) |-> $past(wake_ok_unit))
		else $error("unit irq flag without wake enable");

	unit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_irq[BIT_UNIT_IRQ] |=> sts_irq[BIT_UNIT_IRQ])
		else $error("unit irq not recorded");

	key_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_irq[BIT_KEY_IRQ]) |-> $past(wake_ok_key))
		else $error("keypad irq flag without wake enable");

	ptr_irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_irq[BIT_PTR_IRQ] |=> sts_irq[BIT_PTR_IRQ])
		else $error("pointer irq not recorded");

	p0_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_p0[7] |=> sts_p0[7])
		else $error("port0 pin7 event not recorded");

	p0_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ((sts_p0 & en_p0) != 8'h00) |=> global_wake_flag)
		else $error("port0 gate did not reach global flag");

	p1_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ((sts_p1 & en_p1) != 8'h00) |=> global_wake_flag)
		else $error("port1 gate did not reach global flag");

	dev_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ((sts_dev & en_dev) != 8'h00) |=> global_wake_flag)
		else $error("device gate did not reach global flag");

	irq_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ((sts_irq & en_irq) != 8'h00) |=> global_wake_flag)
		else $error("irq gate did not reach global flag");

	en_reset_a: assert property (@(posedge pclk)
		!presetn |-> (en_p0 == 8'h00) && (en_p1 == 8'h00) && (en_dev == 8'h00) && (en_irq == 8'h00))
		else $error("enable not zero in reset");

	sts_reset_a: assert property (@(posedge pclk)
		!presetn |-> (sts_p0 == 8'h00) && (sts_p1 == 8'h00) && (sts_dev == 8'h00) && (sts_irq == 8'h00))
		else $error("status not zero in reset");

	glb_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !any_enabled && wr_acc && widx == IDX_GLB_STS && wbyte[0] |=> !global_wake_flag)
		else $error("global flag not cleared");

	sci_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !(global_wake_flag && global_wake_gate) |=> !sci_out)
		else $error("interrupt without gated flag");

	rsvd_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en_p1[7:4] == 4'h0) && (en_dev[1:0] == 2'b00) && (sts_irq[7:5] == 3'h0))
		else $error("reserved enable or status bit set");

	p1_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		paddr[5:2] == IDX_STS_P1 |-> rbyte == sts_p1)
		else $error("port1 status not at its index");

	dev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		paddr[5:2] == IDX_STS_DEV |-> rbyte == sts_dev)
		else $error("device status not at its index");

	phone_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sts_dev[BIT_PHONE]) |-> $past(set_dev[BIT_PHONE]))
		else $error("phone flag without falling edge");

	w1c_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_acc && widx == IDX_STS_P1 && !wbyte[3] && sts_p1[3] |=> sts_p1[3])
		else $error("zero write cleared a flag");
endmodule
`default_nettype wire
